// ===== src/bsw_pkg.sv
// constants, types and register map of the dual bus switch block
package bsw_pkg;

	// ==========================================
	// station numbers and message kinds
	localparam logic [4:0] STN_RED_LO    = 5'h1E;  // station 30
	localparam logic [4:0] STN_RED_HI    = 5'h1F;  // station 31
	localparam logic [4:0] CTRL_STN_RST  = 5'h1F;
	localparam logic [1:0] KIND_FAULT    = 2'h1;
	localparam logic [1:0] KIND_CFG      = 2'h2;
	localparam logic [1:0] REQ_DIAG      = 2'h1;
	localparam logic [1:0] REQ_BLOCK     = 2'h2;

	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_LOSS      = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_DIAG      = 8'h0C;
	localparam logic [7:0] OFS_OUTS      = 8'h10;
	localparam logic [7:0] OFS_EXTADDR   = 8'h14;
	localparam logic [7:0] OFS_EXTDATA   = 8'h18;

	// ==========================================
	// control field positions and reset values
	localparam int CTRL_RED_BIT          = 0;
	localparam int CTRL_DRV_BIT          = 1;
	localparam int CTRL_PRES_BIT         = 2;
	localparam int CTRL_COMBO_BIT        = 3;
	localparam int CTRL_EXT_BIT          = 4;
	localparam int CTRL_STN_LSB          = 8;
	localparam logic [31:0] CTRL_RST     = {19'h0, CTRL_STN_RST, 8'h00};
	localparam logic [7:0] LOSS_RST      = 8'h03;
	localparam logic [7:0] GRACE_RST     = 8'h19;

	// ==========================================
	// changeover timing, in milliseconds and scans
	localparam int CHANGE_MS             = 1000;
	localparam int SCAN_MAX_MS           = 40;
	localparam logic [7:0] LOSS_MAX      = 8'(CHANGE_MS / SCAN_MAX_MS - 1);

	// ==========================================
	// carriers
	typedef struct packed {
		logic       valid;
		logic [1:0] kind;
		logic [4:0] dest;
	} bsw_notice_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] kind;
		logic [4:0] src;
	} bsw_req_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [4:0]  dest;
		logic [15:0] data;
	} bsw_resp_t;

	typedef enum logic [1:0] {SW_ON, SW_PROBE, SW_WAIT} bsw_sw_state_t;
	typedef enum logic [1:0] {N_IDLE, N_SEND} bsw_ntc_state_t;
	typedef enum logic [1:0] {R_IDLE, R_DIAG, R_FETCH, R_BLK} bsw_rsp_state_t;

endpackage

// ===== src/bsw_ext_mem.sv
// small memory for the extended data set, registered read port
module bsw_ext_mem
	import bsw_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW    = $clog2(DEPTH)
)
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// read port
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	initial
	begin
		if (DEPTH < 2) $error("bsw_ext_mem: depth too small");
	end

	// storage, no reset on the array
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// registered read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_data <= '0;
		else
			rd_data <= mem[rd_addr];
	end

endmodule

// ===== src/bsw_scan_timer.sv
// counts bus scans since the last clear, a valid controller message or a bus switch restart
module bsw_scan_timer
	import bsw_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// events
	input  wire logic       scan_tick,
	input  wire logic       clear,
	// scans counted, saturating
	output logic      [7:0] count
);

	// restart on clear, count scans otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= 8'h00;
		else if (clear)
			count <= 8'h00;
		else if (scan_tick && count != 8'hFF)
			count <= count + 8'h01;
	end

endmodule

// ===== src/bsw_top.sv
// dual bus switch driver, fault notices and data broadcast
// ==========================================
//
// Added by the designer: the APB interface to the registers and the register addresses.
module bsw_top
	import bsw_pkg::*;
#(
	parameter int NCKT    = 16,
	parameter int SW_CKT  = 0,
	parameter int EXT_LEN = 16
)
(
	// clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// apb slave
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	// bus side events, same clock
	input  wire logic            scan_tick,
	input  wire logic            ctrl_msg_valid,
	input  wire logic            switch_request_message,
	input  wire logic            fault_event,
	input  wire logic            cfg_change_event,
	input  wire logic            monitor_assign_valid,
	input  wire logic [4:0]      monitor_assign_stn,
	// handheld terminal, same clock
	input  wire logic            handheld_terminal_switch,
	input  wire logic            handheld_terminal_force,
	input  wire logic            handheld_terminal_force_val,
	// field pins, asynchronous
	input  wire logic [NCKT-1:0] in_pins,
	input  wire logic [NCKT-1:0] fb_pins,
	// notices to the bus
	output bsw_notice_t          notice,
	input  wire logic            notice_ready,
	// read requests and answers
	input  bsw_req_t             req,
	output bsw_resp_t            resp,
	input  wire logic            resp_ready,
	// broadcast of inputs
	output logic                 bcast_valid,
	output logic      [NCKT-1:0] bcast_data,
	// field outputs
	output logic      [NCKT-1:0] out_circuits,
	output logic                 bus_switch_unit_drive,
	output logic                 bus_switch_unit_led,
	output logic                 outputs_defaulted
);

	localparam int EAW = $clog2(EXT_LEN);

	initial
	begin
		if (NCKT < 1 || NCKT > 32) $error("bsw_top: NCKT out of range");
		if (SW_CKT < 0 || SW_CKT >= NCKT) $error("bsw_top: SW_CKT out of range");
		if (EXT_LEN < 2 || EXT_LEN > 256) $error("bsw_top: EXT_LEN out of range");
	end

	// ==========================================
	// copy selection helpers
	function automatic logic [1:0] next_copy(input logic [1:0] cur, input logic red,
		input logic mon);
		if (cur == 2'd0 && red)
			next_copy = 2'd1;
		else if (cur != 2'd2 && mon)
			next_copy = 2'd2;
		else
			next_copy = 2'd3;
	endfunction

	function automatic logic [4:0] copy_dest(input logic [1:0] idx, input logic red,
		input logic [4:0] ctl, input logic [4:0] mon);
		case (idx)
			2'd0:    copy_dest = red ? STN_RED_LO : ctl;
			2'd1:    copy_dest = STN_RED_HI;
			default: copy_dest = mon;
		endcase
	endfunction

	// ==========================================
	// registers
	logic [31:0]     ctrl_reg;
	logic [7:0]      loss_reg;
	logic [7:0]      grace_reg;
	logic [15:0]     diag_reg;
	logic [NCKT-1:0] outs_reg;
	logic [EAW-1:0]  extaddr_reg;
	logic            mon_valid_reg;
	logic [4:0]      mon_stn_reg;
	logic            bus_b_reg;
	bsw_sw_state_t   sw_state_reg;
	logic            pend_fault_reg;
	logic            pend_cfg_reg;
	bsw_ntc_state_t  ntc_state_reg;
	logic [1:0]      copy_reg;
	bsw_rsp_state_t  rsp_state_reg;
	logic [EAW-1:0]  word_reg;
	logic [NCKT-1:0] in_s1_reg;
	logic [NCKT-1:0] in_s2_reg;
	logic [NCKT-1:0] fb_s1_reg;
	logic [NCKT-1:0] fb_s2_reg;

	logic            cfg_red;
	logic            cfg_drv;
	logic            cfg_pres;
	logic            cfg_combo;
	logic            cfg_ext;
	logic [4:0]      cfg_stn;
	logic [7:0]      loss_lim;
	logic [7:0]      scan_count;
	logic            lost;
	logic            sw_cmd;
	logic            sw_restart;
	logic            take_fault;
	logic            take_cfg;
	logic            apb_wr;
	logic            mem_wr;
	logic [15:0]     mem_rdata;
	logic [EAW-1:0]  word_next;
	logic            sw_level;

	assign cfg_red   = ctrl_reg[CTRL_RED_BIT];
	assign cfg_drv   = ctrl_reg[CTRL_DRV_BIT];
	assign cfg_pres  = ctrl_reg[CTRL_PRES_BIT];
	assign cfg_combo = ctrl_reg[CTRL_COMBO_BIT];
	assign cfg_ext   = ctrl_reg[CTRL_EXT_BIT];
	assign cfg_stn   = ctrl_reg[CTRL_STN_LSB +: 5];

	// ==========================================
	// apb slave, one wait state, write on the pready edge
	assign apb_wr = psel && penable && pready && pwrite;
	assign mem_wr = apb_wr && paddr == OFS_EXTDATA;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (psel && penable && !pready)
		begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			case (paddr)
				OFS_CTRL:    prdata <= ctrl_reg;
				OFS_LOSS:    prdata <= {16'h0000, grace_reg, loss_reg};
				OFS_STATUS:  prdata <= {18'h0, mon_stn_reg, mon_valid_reg,
					pend_cfg_reg, pend_fault_reg, 4'(sw_state_reg), lost, bus_b_reg};
				OFS_DIAG:    prdata <= {16'h0000, diag_reg};
				OFS_OUTS:    prdata <= 32'(outs_reg);
				OFS_EXTADDR: prdata <= 32'(extaddr_reg);
				OFS_EXTDATA: prdata <= 32'h0000_0000;
				default:     pslverr <= 1'b1;
			endcase
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// software written configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg    <= CTRL_RST;
			loss_reg    <= LOSS_RST;
			grace_reg   <= GRACE_RST;
			diag_reg    <= 16'h0000;
			outs_reg    <= '0;
			extaddr_reg <= '0;
		end
		else if (apb_wr)
		begin
			case (paddr)
				OFS_CTRL:    ctrl_reg <= pwdata & 32'h0000_1F1F;
				OFS_LOSS:
				begin
					loss_reg  <= pwdata[7:0];
					grace_reg <= pwdata[15:8];
				end
				OFS_DIAG:    diag_reg <= pwdata[15:0];
				OFS_OUTS:    outs_reg <= pwdata[NCKT-1:0];
				OFS_EXTADDR: extaddr_reg <= pwdata[EAW-1:0];
				OFS_EXTDATA: extaddr_reg <= extaddr_reg + 1'b1;  // auto increment
				default:     ;
			endcase
		end
	end

	// ==========================================
	// loss of communication detection
	always_comb
	begin
		loss_lim = loss_reg;
		if (loss_reg > LOSS_MAX)
			loss_lim = LOSS_MAX;
		if (loss_reg == 8'h00)
			loss_lim = 8'h01;
	end

	assign lost = scan_count >= loss_lim;

	bsw_scan_timer u_timer
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.scan_tick (scan_tick),
		.clear     (ctrl_msg_valid || sw_restart),
		.count     (scan_count)
	);

	// ==========================================
	// bus switch state machine
	assign sw_cmd = switch_request_message || handheld_terminal_switch;

	always_comb
	begin
		sw_restart = 1'b0;
		case (sw_state_reg)
			SW_ON:    sw_restart = cfg_drv && (lost || sw_cmd);
			SW_PROBE: sw_restart = cfg_drv && handheld_terminal_switch;
			SW_WAIT:  sw_restart = 1'b0;
			default:  sw_restart = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sw_state_reg <= SW_ON;
			bus_b_reg    <= 1'b0;                             // bus A after power up
		end
		else
		begin
			if (sw_restart)
				bus_b_reg <= !bus_b_reg;
			case (sw_state_reg)
				SW_ON:
					if (sw_restart)
						sw_state_reg <= SW_PROBE;
				SW_PROBE:
					if (ctrl_msg_valid && !sw_restart)
						sw_state_reg <= SW_ON;
					else if (lost && !sw_restart)
						sw_state_reg <= SW_WAIT;
				SW_WAIT:
					if (ctrl_msg_valid)
						sw_state_reg <= SW_ON;
				default:
					sw_state_reg <= SW_ON;
			endcase
		end
	end

	// switch drive level, terminal force overrides
	assign sw_level = handheld_terminal_force ? handheld_terminal_force_val : bus_b_reg;

	// ==========================================
	// field outputs and switch drive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bus_switch_unit_drive <= 1'b0;
			bus_switch_unit_led   <= 1'b0;
			outputs_defaulted     <= 1'b0;
		end
		else
		begin
			bus_switch_unit_drive <= cfg_drv && sw_level;
			bus_switch_unit_led   <= cfg_drv && sw_level;
			// defaulting waits out the grace scans of a switch
			outputs_defaulted     <= cfg_pres
				? {1'b0, scan_count} >= 9'(loss_lim) + 9'(grace_reg)
				: lost;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCKT; gi++)
		begin : g_ckt
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					out_circuits[gi] <= 1'b0;
				else if (cfg_drv && gi == SW_CKT)
					out_circuits[gi] <= sw_level;
				else
					out_circuits[gi] <= outs_reg[gi];
			end
		end
	endgenerate

	// ==========================================
	// pin synchronisers and broadcast
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			in_s1_reg <= '0;
			in_s2_reg <= '0;
			fb_s1_reg <= '0;
			fb_s2_reg <= '0;
		end
		else
		begin
			in_s1_reg <= in_pins;
			in_s2_reg <= in_s1_reg;
			fb_s1_reg <= fb_pins;
			fb_s2_reg <= fb_s1_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bcast_valid <= 1'b0;
			bcast_data  <= '0;
		end
		else
		begin
			bcast_valid <= scan_tick;
			if (scan_tick)
				bcast_data <= cfg_combo ? fb_s2_reg : in_s2_reg;
		end
	end

	// ==========================================
	// monitor assignment
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mon_valid_reg <= 1'b0;
			mon_stn_reg   <= 5'h00;
		end
		else if (monitor_assign_valid)
		begin
			mon_valid_reg <= 1'b1;
			mon_stn_reg   <= monitor_assign_stn;
		end
	end

	// ==========================================
	// notice pending flags, a new event wins over the clear
	assign take_fault = ntc_state_reg == N_IDLE && pend_fault_reg;
	assign take_cfg   = ntc_state_reg == N_IDLE && !pend_fault_reg && pend_cfg_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_fault_reg <= 1'b0;
			pend_cfg_reg   <= 1'b0;
		end
		else
		begin
			pend_fault_reg <= (pend_fault_reg && !take_fault) || fault_event;
			pend_cfg_reg   <= (pend_cfg_reg && !take_cfg) || cfg_change_event;
		end
	end

	// notice dispatch, one copy per destination
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ntc_state_reg <= N_IDLE;
			copy_reg      <= 2'd0;
			notice        <= '0;
		end
		else
		begin
			case (ntc_state_reg)
				N_IDLE:
					if (take_fault || take_cfg)
					begin
						ntc_state_reg <= N_SEND;
						copy_reg      <= 2'd0;
						notice.valid  <= 1'b1;
						notice.kind   <= take_fault ? KIND_FAULT : KIND_CFG;
						notice.dest   <= copy_dest(2'd0, cfg_red, cfg_stn, mon_stn_reg);
					end
				N_SEND:
					if (notice_ready)
					begin
						if (next_copy(copy_reg, cfg_red, mon_valid_reg) == 2'd3)
						begin
							ntc_state_reg <= N_IDLE;
							notice.valid  <= 1'b0;
						end
						else
						begin
							copy_reg    <= next_copy(copy_reg, cfg_red, mon_valid_reg);
							notice.dest <= copy_dest(next_copy(copy_reg, cfg_red,
								mon_valid_reg), cfg_red, cfg_stn, mon_stn_reg);
						end
					end
				default:
					ntc_state_reg <= N_IDLE;
			endcase
		end
	end

	// ==========================================
	// read request answers
	bsw_ext_mem #(.WIDTH(16), .DEPTH(EXT_LEN)) u_mem
	(
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (mem_wr),
		.wr_addr (extaddr_reg),
		.wr_data (pwdata[15:0]),
		.rd_addr (word_next),
		.rd_data (mem_rdata)
	);

	// fetch address runs one step ahead of the registered read port
	always_comb
	begin
		word_next = word_reg;
		if (rsp_state_reg == R_IDLE)
			word_next = '0;
		else if (rsp_state_reg == R_BLK && resp_ready)
			word_next = word_reg + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rsp_state_reg <= R_IDLE;
			word_reg      <= '0;
			resp          <= '0;
		end
		else
		begin
			case (rsp_state_reg)
				R_IDLE:
					if (req.valid && req.kind == REQ_DIAG)
					begin
						rsp_state_reg <= R_DIAG;
						resp          <= {1'b1, 1'b1, req.src, diag_reg};
					end
					else if (req.valid && req.kind == REQ_BLOCK && cfg_ext)
					begin
						rsp_state_reg <= R_FETCH;
						resp.dest     <= req.src;
						word_reg      <= '0;
					end
				R_DIAG:
					if (resp_ready)
					begin
						rsp_state_reg <= R_IDLE;
						resp.valid    <= 1'b0;
					end
				R_FETCH:
				begin
					rsp_state_reg <= R_BLK;
					resp.valid    <= 1'b1;
					resp.data     <= mem_rdata;
					resp.last     <= word_reg == EAW'(EXT_LEN - 1);
				end
				R_BLK:
					if (resp_ready)
					begin
						resp.valid <= 1'b0;
						if (resp.last)
							rsp_state_reg <= R_IDLE;
						else
						begin
							rsp_state_reg <= R_FETCH;
							word_reg      <= word_reg + 1'b1;
						end
					end
				default:
					rsp_state_reg <= R_IDLE;
			endcase
		end
	end

endmodule

// ===== dv/bsw_top_properties.sv
// port checker for the dual bus switch block
module bsw_top_properties
	import bsw_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// bus side
	input wire logic        scan_tick,
	input wire logic        fault_event,
	input wire logic        notice_ready,
	input wire logic        resp_ready,
	input wire bsw_notice_t notice,
	input wire bsw_resp_t   resp,
	input wire logic        bcast_valid,
	// switch unit
	input wire logic        bus_switch_unit_drive,
	input wire logic        bus_switch_unit_led
);
	// ==========================================
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_pready_wait: assert property (psel && penable && !pready |=> pready && !$past(pready))
		else $error("apb answer not one cycle after access");
	a_notice_soon: assert property (fault_event && !notice.valid |-> ##[1:2] notice.valid)
		else $error("fault notice late");
	a_notice_hold: assert property (notice.valid && !notice_ready |=> notice.valid && $stable(notice))
		else $error("notice changed before accept");
	a_notice_drop: assert property ($fell(notice.valid) |-> $past(notice_ready))
		else $error("notice dropped without accept");
	a_resp_hold: assert property (resp.valid && !resp_ready |=> resp.valid && $stable(resp))
		else $error("answer changed before accept");
	a_bcast_tick: assert property (bcast_valid == $past(scan_tick))
		else $error("broadcast not one cycle after scan");
	a_led_follows: assert property (bus_switch_unit_led == bus_switch_unit_drive)
		else $error("indicator differs from drive");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("error without ready");

	// main scenarios reached
	c_notice: cover property (notice.valid && notice_ready);
	c_last: cover property (resp.valid && resp.last && resp_ready);
	c_bus_b: cover property ($rose(bus_switch_unit_drive));
	c_err: cover property (pslverr);
endmodule

bind bsw_top bsw_top_properties bsw_top_properties_i (.pclk, .presetn, .psel, .penable,
	.pready, .pslverr, .scan_tick, .fault_event, .notice_ready, .resp_ready, .notice, .resp,
	.bcast_valid, .bus_switch_unit_drive, .bus_switch_unit_led);

// ===== dv/bsw_ctrl_model.sv
// bus controller model: scans, controller messages, accepts
module bsw_ctrl_model
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// controller still talking on the bus
	input wire logic alive,
	// toward the block
	output logic     scan_tick,
	output logic     ctrl_msg_valid,
	output logic     notice_ready,
	output logic     resp_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg;

	// ==========================================
	// one bus scan every 20 cycles
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= (cnt_reg == 8'h13) ? 8'h00 : cnt_reg + 8'h01;

	// message five cycles after each scan; controller drives no field output
	assign scan_tick      = presetn && cnt_reg == 8'h00;
	assign ctrl_msg_valid = alive && cnt_reg == 8'h05;
	// accepts mix prompt and stalled cycles
	assign notice_ready   = cnt_reg[0] | cnt_reg[2];
	assign resp_ready     = cnt_reg[1];
endmodule

// ===== dv/bsw_top_tb.sv
// self-checking bench for the dual bus switch block
module bsw_top_tb
	import bsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EXT_N = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        fault_event, cfg_change_event, monitor_assign_valid, switch_request_message;
	logic [4:0]  monitor_assign_stn, mon;
	logic        ht_sw, ht_force, ht_val, alive, bcast_valid, drive, led, defaulted;
	logic        scan_tick, ctrl_msg_valid, notice_ready, resp_ready;
	logic [15:0] in_pins, fb_pins, bcast_data, out_circuits, dw, outs;
	bsw_notice_t notice;
	bsw_req_t    req;
	bsw_resp_t   resp;
	bsw_notice_t nq[$], eq[$];
	logic [21:0] rq[$];
	logic [15:0] ext[EXT_N];
	int          bad_count, tests_run, cyc;

	bsw_top #(.EXT_LEN(EXT_N)) bsw_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .scan_tick, .ctrl_msg_valid,
		.switch_request_message, .fault_event, .cfg_change_event, .monitor_assign_valid,
		.monitor_assign_stn, .handheld_terminal_switch(ht_sw),
		.handheld_terminal_force(ht_force), .handheld_terminal_force_val(ht_val), .in_pins,
		.fb_pins, .notice, .notice_ready, .req, .resp, .resp_ready, .bcast_valid, .bcast_data,
		.out_circuits, .bus_switch_unit_drive(drive), .bus_switch_unit_led(led),
		.outputs_defaulted(defaulted));
	bsw_ctrl_model bsw_ctrl_model_i (.pclk, .presetn, .alive, .scan_tick, .ctrl_msg_valid,
		.notice_ready, .resp_ready);

	// ==========================================
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// cycle ceiling and accepted transfers
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up();
		end
		if (notice.valid === 1'b1 && notice_ready === 1'b1)
			nq.push_back(notice);
		if (resp.valid === 1'b1 && resp_ready === 1'b1)
			rq.push_back({resp.dest, resp.last, resp.data});
	end

	// ==========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// expected copies of one notice
	function automatic void exp_notes(logic red, logic mv, logic [4:0] ms, logic [1:0] k);
		if (red)
		begin
			eq.push_back({1'b1, k, STN_RED_LO});
			eq.push_back({1'b1, k, STN_RED_HI});
		end
		else
			eq.push_back({1'b1, k, CTRL_STN_RST});
		if (mv)
			eq.push_back({1'b1, k, ms});
	endfunction

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk_notes();
		repeat (40) @(posedge pclk);
		chk("notice count", eq.size(), nq.size());
		for (int i = 0; i < eq.size() && i < nq.size(); i++)
			chk("notice", eq[i], nq[i]);
		eq = {};
		nq = {};
	endtask

	task automatic wait_bc();
		do
			@(posedge pclk);
		while (bcast_valid !== 1'b1);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		seed = 32'hB7516789;
		{presetn, psel, penable, pwrite, fault_event, cfg_change_event} = '0;
		{monitor_assign_valid, switch_request_message, ht_sw, ht_force, ht_val} = '0;
		{paddr, pwdata, monitor_assign_stn, in_pins, fb_pins, req} = '0;
		{cyc, bad_count, tests_run} = '0;
		alive = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unmapped offset, loss readback, outputs
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("ctrl reset", CTRL_RST, rd);
		chk("drive reset", 32'h0, drive);
		apb(1'b0, OFS_LOSS, 32'h0);
		chk("loss reset", {16'h0, GRACE_RST, LOSS_RST}, rd);
		apb(1'b1, 8'h1C, 32'hFFFFFFFF);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, OFS_LOSS, 32'h00001928);
		apb(1'b0, OFS_LOSS, 32'h0);
		chk("loss readback", 32'h00001928, rd);
		outs = 16'(rnd());
		apb(1'b1, OFS_OUTS, {16'h0000, outs});
		repeat (2) @(posedge pclk);
		chk("outputs", outs, out_circuits);
		$display("test registers done");
		// single notice, redundant copies, monitor copies with fault first
		@(posedge pclk) fault_event <= 1'b1;
		@(posedge pclk) fault_event <= 1'b0;
		exp_notes(1'b0, 1'b0, 5'h00, KIND_FAULT);
		chk_notes();
		apb(1'b1, OFS_CTRL, CTRL_RST | 32'h1);
		@(posedge pclk) cfg_change_event <= 1'b1;
		@(posedge pclk) cfg_change_event <= 1'b0;
		exp_notes(1'b1, 1'b0, 5'h00, KIND_CFG);
		chk_notes();
		mon = 5'(rnd()) & 5'h0F;
		@(posedge pclk) {monitor_assign_valid, monitor_assign_stn} <= {1'b1, mon};
		@(posedge pclk) monitor_assign_valid <= 1'b0;
		@(posedge pclk) {fault_event, cfg_change_event} <= 2'b11;
		@(posedge pclk) {fault_event, cfg_change_event} <= 2'b00;
		exp_notes(1'b1, 1'b1, mon, KIND_FAULT);
		exp_notes(1'b1, 1'b1, mon, KIND_CFG);
		chk_notes();
		$display("test notices done");
		// block read refused without ext bit, diagnostics read, then extended data set
		@(posedge pclk) req <= '{1'b1, REQ_BLOCK, 5'h05};
		@(posedge pclk) req <= '0;
		dw = 16'(rnd());
		apb(1'b1, OFS_DIAG, {16'h0, dw});
		@(posedge pclk) req <= '{1'b1, REQ_DIAG, 5'h03};
		@(posedge pclk) req <= '0;
		apb(1'b1, OFS_CTRL, CTRL_RST | 32'h11);
		apb(1'b1, OFS_EXTADDR, 32'h0);
		for (int i = 0; i < EXT_N; i++)
		begin
			ext[i] = 16'(rnd());
			apb(1'b1, OFS_EXTDATA, {16'h0, ext[i]});
		end
		@(posedge pclk) req <= '{1'b1, REQ_BLOCK, 5'h05};
		@(posedge pclk) req <= '0;
		repeat (60) @(posedge pclk);
		chk("answer count", EXT_N + 1, rq.size());
		chk("diag word", {5'h03, 1'b1, dw}, rq[0]);
		for (int i = 0; i < EXT_N; i++)
			chk("block word", {5'h05, (int'(i) == EXT_N - 1), ext[i]}, rq[i + 1]);
		$display("test reads done");
		// broadcast of inputs, then of feedback as combination block
		for (int k = 0; k < 4; k++)
		begin
			if (k == 2)
				apb(1'b1, OFS_CTRL, CTRL_RST | 32'h19);
			wait_bc();
			in_pins <= 16'(rnd());
			fb_pins <= 16'(rnd());
			wait_bc();
			chk("broadcast", (k >= 2) ? fb_pins : in_pins, bcast_data);
		end
		$display("test broadcast done");
		// loss at clamped limit, probe and wait, return, request, terminal force and switch
		apb(1'b1, OFS_CTRL, CTRL_RST | 32'h6);
		alive <= 1'b0;
		for (int i = 0; i < 600 && drive !== 1'b1; i++)
			@(posedge pclk);
		apb(1'b1, OFS_LOSS, 32'h00001902);
		chk("drive after loss", 32'h1, drive);
		chk("indicator on b", 32'h1, led);
		chk("switch circuit", 32'h1, out_circuits[0]);
		chk("other circuits", outs[15:1], out_circuits[15:1]);
		chk("no early default", 32'h0, defaulted);
		repeat (300) @(posedge pclk);
		chk("hold in wait", 32'h1, drive);
		chk("defer default", 32'h0, defaulted);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("status", {18'h0, mon, 3'h4, 4'h2, 2'h3}, rd);
		alive <= 1'b1;
		repeat (100) @(posedge pclk);
		chk("stay on b", 32'h1, drive);
		@(posedge pclk) switch_request_message <= 1'b1;
		@(posedge pclk) switch_request_message <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("request to a", 32'h0, drive);
		@(posedge pclk) {ht_force, ht_val} <= 2'b11;
		repeat (4) @(posedge pclk);
		chk("forced", 32'h1, drive);
		@(posedge pclk) {ht_force, ht_val} <= 2'b00;
		repeat (4) @(posedge pclk);
		chk("unforced", 32'h0, drive);
		@(posedge pclk) ht_sw <= 1'b1;
		@(posedge pclk) ht_sw <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("terminal switch", 32'h1, drive);
		$display("test switch done");
		wrap_up();
	end
endmodule
